// ==== rtl/dsa_core.v ====
/*
  Data-space access unit: address selection, alignment, byte lanes,
  dual-operand fetch, pointer stepping, software stack and its checks.
  Assumes the core raises at most one of push, pop, access or dual fetch
  per cycle and writes the stack limit before using the stack.
*/
`timescale 1ns/100ps
`include "dsa_map.vh"

module dsa_core (
  input wire clk_i,
  input wire rst_b_i,
  input wire acc_req_i,
  input wire acc_write_i,
  input wire acc_byte_i,
  input wire [1:0] acc_src_i,
  input wire [15:0] acc_addr_i,
  input wire [15:0] acc_wdata_i,
  input wire [15:0] wreg_old_i,
  input wire mac_req_i,
  input wire mac_x_sel_i,
  input wire mac_y_sel_i,
  input wire [15:0] x_fetch_pointer_a_i,
  input wire [15:0] x_fetch_pointer_b_i,
  input wire [15:0] y_fetch_pointer_a_i,
  input wire [15:0] y_fetch_pointer_b_i,
  input wire push_i,
  input wire [1:0] push_kind_i,
  input wire [15:0] push_data_i,
  input wire [7:0] status_low_byte_i,
  input wire pop_i,
  input wire stack_limit_we_i,
  input wire [15:0] stack_limit_wdata_i,
  input wire [15:0] step_ptr_i,
  input wire step_byte_i,
  input wire step_word_only_i,
  output reg [15:0] x_rdata_o,
  output reg [15:0] y_rdata_o,
  output reg rd_valid_o,
  output reg mac_valid_o,
  output reg [15:0] wreg_load_o,
  output reg [15:0] effective_addr_o,
  output reg [15:0] stack_pointer_o,
  output reg [15:0] ptr_next_o,
  output reg addr_err_trap_o,
  output reg stack_err_trap_o
);

  // Implemented data RAM window
  function in_ram;
    input [15:0] a;
    begin
      in_ram = (a >= `DSA_RAM_FIRST) && (a <= `DSA_RAM_LAST);
    end
  endfunction

  // Y region inside the RAM window
  function in_y;
    input [15:0] a;
    begin
      in_y = (a >= `DSA_Y_FIRST) && (a <= `DSA_Y_LAST);
    end
  endfunction

  // Word index into the memory array
  function [`DSA_MEM_AW-1:0] word_idx;
    input [15:0] a;
    reg [15:0] off;
    begin
      off = a - `DSA_RAM_FIRST;
      word_idx = off[`DSA_MEM_AW:1];
    end
  endfunction

  // Stack range check; equality with the limit is still legal
  function stack_out;
    input [15:0] a;
    input [15:0] lim;
    begin
      stack_out = (a > lim) || (a < `DSA_STACK_FLOOR); // [RULE_19] [RULE_20]
    end
  endfunction

  // Write strobes: a byte touches only its own lane
  function [1:0] lane_sel;
    input byte_op;
    input odd;
    begin
      if (!byte_op) begin
        lane_sel = `DSA_LANE_BOTH;
      end else if (odd) begin
        lane_sel = `DSA_LANE_HI; // [RULE_08]
      end else begin
        lane_sel = `DSA_LANE_LO; // [RULE_08]
      end
    end
  endfunction

  // Word written by each kind of push
  function [15:0] push_word;
    input [1:0] kind;
    input [15:0] data;
    input [7:0] status_lo;
    begin
      case (kind)
        `DSA_PUSH_CALL: begin
          push_word = {8'h00, data[7:0]}; // [RULE_16]
        end
        `DSA_PUSH_EXC: begin
          push_word = {status_lo, data[7:0]}; // [RULE_17]
        end
        default: begin
          push_word = data;
        end
      endcase
    end
  endfunction

  reg [15:0] stack_pointer_reg;
  reg [15:0] stack_limit_reg;

  // Stage one: request held while memory reads
  reg s1_rd;
  reg s1_mac;
  reg s1_zero;
  reg s1_y_zero;
  reg s1_byte;
  reg s1_hi;
  reg [15:0] s1_wreg_old;

  // Request decode
  reg do_push;
  reg do_pop;
  reg do_acc;
  reg do_mac;
  reg [15:0] effective_addr;
  reg [15:0] y_addr;
  reg word_op;
  reg is_write;
  reg misaligned;
  reg stack_ea;
  reg stack_bad;
  reg x_zero;
  reg y_zero;
  reg [15:0] wdata;
  reg [1:0] lanes;
  reg [15:0] next_sp;

  wire [15:0] ram_x_rdata;
  wire [15:0] ram_y_rdata;
  wire [1:0] ram_we;

  always @* begin
    do_push = push_i;
    do_pop = pop_i && !push_i;
    do_acc = acc_req_i && !push_i && !pop_i;
    do_mac = mac_req_i && !push_i && !pop_i && !acc_req_i;
    effective_addr = acc_addr_i;
    y_addr = `DSA_ZERO_WORD;
    word_op = 1'b1;
    is_write = 1'b0;
    stack_ea = 1'b0;
    wdata = acc_wdata_i;
    next_sp = stack_pointer_reg;
    if (do_push) begin
      effective_addr = stack_pointer_reg;
      is_write = 1'b1;
      stack_ea = 1'b1;
      next_sp = stack_pointer_reg + `DSA_STEP_WORD; // [RULE_15]
      wdata = push_word(push_kind_i, push_data_i, status_low_byte_i);
    end else if (do_pop) begin
      // Pop reads the word just below the free slot
      effective_addr = stack_pointer_reg - `DSA_STEP_WORD; // [RULE_15]
      stack_ea = 1'b1;
      next_sp = effective_addr;
    end else if (do_acc) begin
      word_op = !acc_byte_i;
      is_write = acc_write_i;
      case (acc_src_i)
        `DSA_SRC_NEAR: begin
          effective_addr = {3'h0, acc_addr_i[`DSA_NEAR_W-1:0]}; // [RULE_13]
        end
        `DSA_SRC_DIRECT: begin
          effective_addr = acc_addr_i; // [RULE_14]
        end
        `DSA_SRC_STACK: begin
          effective_addr = stack_pointer_reg;
          stack_ea = 1'b1;
        end
        default: begin
          effective_addr = acc_addr_i; // [RULE_04]
        end
      endcase
    end else if (do_mac) begin
      // Only the dual fetch sees X and Y apart
      effective_addr = mac_x_sel_i ? x_fetch_pointer_b_i :
                       x_fetch_pointer_a_i; // [RULE_22]
      y_addr = mac_y_sel_i ? y_fetch_pointer_b_i :
               y_fetch_pointer_a_i;
    end
    misaligned = (do_push || do_pop || do_acc || do_mac) && word_op &&
                 (effective_addr[0] || (do_mac && y_addr[0])); // [RULE_10]
    stack_bad = stack_ea &&
                stack_out(effective_addr, stack_limit_reg); // [RULE_19]
    x_zero = !in_ram(effective_addr) ||
             (do_mac && in_y(effective_addr)); // [RULE_01] [RULE_02]
    y_zero = !in_y(y_addr); // [RULE_03]
    lanes = lane_sel(!word_op, effective_addr[0]); // [RULE_08]
    // Byte data copied to both lanes; the strobe picks one
    if (!word_op) begin
      wdata = {wdata[7:0], wdata[7:0]};
    end
  end

  // Misaligned or unmapped writes never reach the array
  assign ram_we = (is_write && !misaligned && in_ram(effective_addr)) ?
                  lanes : 2'h0; // [RULE_11]

  dsa_ram u_ram (
    .clk_i(clk_i),
    .x_addr_i(word_idx(effective_addr)),
    .x_we_i(ram_we),
    .x_wdata_i(wdata),
    .x_rdata_o(ram_x_rdata),
    .y_addr_i(word_idx(y_addr)),
    .y_rdata_o(ram_y_rdata)
  );

  // Stack pointer and limit
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      stack_pointer_reg <= `DSA_SP_RESET;
    end else if (do_push || do_pop) begin
      // Bit zero stays clear; stack words are aligned
      stack_pointer_reg <= {next_sp[15:1], 1'b0};
    end
  end

  // Limit has no reset on purpose; software must load it first
  always @(posedge clk_i) begin
    if (stack_limit_we_i) begin
      stack_limit_reg <= {stack_limit_wdata_i[15:1], 1'b0}; // [RULE_18]
    end
  end

  // Read pipeline, one stage while the array reads
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_rd <= 1'b0;
      s1_mac <= 1'b0;
      s1_zero <= 1'b0;
      s1_y_zero <= 1'b0;
      s1_byte <= 1'b0;
      s1_hi <= 1'b0;
      s1_wreg_old <= `DSA_ZERO_WORD;
    end else begin
      // Reads complete even when misaligned; the trap follows
      s1_rd <= do_pop || do_mac || (do_acc && !acc_write_i); // [RULE_11]
      s1_mac <= do_mac;
      s1_zero <= x_zero;
      s1_y_zero <= y_zero;
      s1_byte <= !word_op;
      s1_hi <= effective_addr[0];
      s1_wreg_old <= wreg_old_i;
    end
  end

  // Trap requests last exactly one cycle per offending access
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      addr_err_trap_o <= 1'b0;
      stack_err_trap_o <= 1'b0;
    end else begin
      addr_err_trap_o <= misaligned; // [RULE_23]
      stack_err_trap_o <= stack_bad; // [RULE_23]
    end
  end

  // Previous-cycle address and updated stack pointer, registered every cycle, request or not
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      effective_addr_o <= `DSA_ZERO_WORD;
      stack_pointer_o <= `DSA_SP_RESET;
    end else begin
      effective_addr_o <= effective_addr;
      if (do_push || do_pop) begin
        stack_pointer_o <= {next_sp[15:1], 1'b0};
      end else begin
        stack_pointer_o <= stack_pointer_reg;
      end
    end
  end

  // Post-modify step; word-only operations ignore the byte flag
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ptr_next_o <= `DSA_ZERO_WORD;
    end else if (step_byte_i && !step_word_only_i) begin
      ptr_next_o <= step_ptr_i + `DSA_STEP_BYTE; // [RULE_09]
    end else begin
      ptr_next_o <= step_ptr_i + `DSA_STEP_WORD; // [RULE_09]
    end
  end

  // Stage two: lane selection and zero substitution
  reg [15:0] x_word;
  reg [15:0] x_out;

  always @* begin
    x_word = s1_zero ? `DSA_ZERO_WORD : ram_x_rdata; // [RULE_01]
    if (s1_byte) begin
      x_out = {8'h00, s1_hi ? x_word[15:8] : x_word[7:0]}; // [RULE_06]
    end else begin
      x_out = x_word; // [RULE_05]
    end
  end

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      x_rdata_o <= `DSA_ZERO_WORD;
      y_rdata_o <= `DSA_ZERO_WORD;
      rd_valid_o <= 1'b0;
      mac_valid_o <= 1'b0;
      wreg_load_o <= `DSA_ZERO_WORD;
    end else begin
      rd_valid_o <= s1_rd;
      mac_valid_o <= s1_mac;
      if (s1_rd) begin
        x_rdata_o <= x_out;
        if (s1_byte) begin
          wreg_load_o <= {s1_wreg_old[15:8], x_out[7:0]}; // [RULE_12]
        end else begin
          wreg_load_o <= x_out;
        end
      end
      if (s1_mac) begin
        y_rdata_o <= s1_y_zero ? `DSA_ZERO_WORD :
                     ram_y_rdata; // [RULE_03] [RULE_07]
      end
    end
  end

endmodule // dsa_core

// ==== rtl/dsa_map.vh ====
/*
  Constants of the data-space access block: address ranges, reset
  values, step sizes and request codes.
  Assumes it is included by bare name from the design files under rtl/.
*/
// Functional notes
// [RULE_01] Unimplemented address reads return zero word
// [RULE_02] Dual fetch: X pointer into Y reads zero
// [RULE_03] Dual fetch: Y pointer into X reads zero
// [RULE_04] Sixteen-bit byte addresses, 64 KB space
// [RULE_05] Sixteen-bit data path, byte-addressable word memory
// [RULE_06] Byte read picks byte, low lane
// [RULE_07] Y path fetches whole words only
// [RULE_08] Shared word decode, per-byte write strobes
// [RULE_09] Post-modify steps one for byte, two word
// [RULE_10] Odd word access raises address error trap
// [RULE_11] Misaligned read completes, misaligned write suppressed
// [RULE_12] Byte load keeps register high byte
// [RULE_13] Near direct field reaches up to 0x1FFF
// [RULE_14] Full sixteen-bit direct field reaches whole X
// [RULE_15] Stack pointer: post-increment push, pre-decrement pop
// [RULE_16] Call push zero-fills upper PC byte
// [RULE_17] Exception push merges status low byte
// [RULE_18] Stack limit unreset, bit zero held zero
// [RULE_19] Push beyond stack limit raises stack error
// [RULE_20] Stack address below 0x0800 raises stack error
// [RULE_21] Core avoids stack read right after limit write
// [RULE_22] Only dual fetch splits X and Y regions
// [RULE_23] Separate one-cycle address and stack trap pulses
`ifndef DSA_MAP_VH
`define DSA_MAP_VH

`define DSA_ZERO_WORD 16'h0000
`define DSA_SP_RESET 16'h0800
`define DSA_STACK_FLOOR 16'h0800
`define DSA_RAM_FIRST 16'h0800
`define DSA_RAM_LAST 16'h27FF
`define DSA_Y_FIRST 16'h1800
`define DSA_Y_LAST 16'h27FF
`define DSA_NEAR_W 13
`define DSA_MEM_AW 12
`define DSA_STEP_BYTE 16'h0001
`define DSA_STEP_WORD 16'h0002

`define DSA_SRC_INDIRECT 2'h0
`define DSA_SRC_NEAR 2'h1
`define DSA_SRC_DIRECT 2'h2
`define DSA_SRC_STACK 2'h3

`define DSA_PUSH_DATA 2'h0
`define DSA_PUSH_CALL 2'h1
`define DSA_PUSH_EXC 2'h2

`define DSA_LANE_LO 2'h1
`define DSA_LANE_HI 2'h2
`define DSA_LANE_BOTH 2'h3

`endif

// ==== rtl/dsa_ram.v ====
/*
  Data memory: two byte lanes sharing a word address decode, one
  read/write port on the X side and one word read port on the Y side.
  Assumes one clock; read data appear one edge after the address.
*/
`timescale 1ns/100ps
`include "dsa_map.vh"

module dsa_ram (
  input wire clk_i,
  input wire [`DSA_MEM_AW-1:0] x_addr_i,
  input wire [1:0] x_we_i,
  input wire [15:0] x_wdata_i,
  output reg [15:0] x_rdata_o,
  input wire [`DSA_MEM_AW-1:0] y_addr_i,
  output reg [15:0] y_rdata_o
);

  localparam DEPTH = 1 << `DSA_MEM_AW;

  genvar lane;
  generate
    for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
      reg [7:0] mem [0:DEPTH-1];
      always @(posedge clk_i) begin
        if (x_we_i[lane]) begin
          mem[x_addr_i] <= x_wdata_i[lane*8 +: 8]; // [RULE_08]
        end
        x_rdata_o[lane*8 +: 8] <= mem[x_addr_i];
        y_rdata_o[lane*8 +: 8] <= mem[y_addr_i]; // [RULE_07]
      end
    end
  endgenerate

endmodule // dsa_ram

// ==== testbench/dsa_core_assertions.sv ====
/* Checker of dsa_core port timing and values.
   Assumes one clock and the synchronous low reset. */
`timescale 1ns/100ps
module dsa_core_chk (
  input wire clk_i,
  input wire rst_b_i,
  input wire acc_req_i,
  input wire acc_write_i,
  input wire acc_byte_i,
  input wire [1:0] acc_src_i,
  input wire [15:0] acc_addr_i,
  input wire [15:0] wreg_old_i,
  input wire mac_req_i,
  input wire push_i,
  input wire pop_i,
  input wire [15:0] step_ptr_i,
  input wire step_byte_i,
  input wire step_word_only_i,
  input wire [15:0] x_rdata_o,
  input wire rd_valid_o,
  input wire mac_valid_o,
  input wire [15:0] wreg_load_o,
  input wire [15:0] effective_addr_o,
  input wire [15:0] stack_pointer_o,
  input wire [15:0] ptr_next_o,
  input wire addr_err_trap_o,
  input wire stack_err_trap_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire acc_go = acc_req_i && !push_i && !pop_i;
  sequence byte_rd_s;
    acc_go && !acc_write_i && acc_byte_i ##2 rd_valid_o;
  endsequence
  sequence mac_s;
    mac_req_i && !acc_req_i && !push_i && !pop_i;
  endsequence
  odd_word_a: assert property (
    acc_go && !acc_byte_i && acc_src_i == 2'h0 && acc_addr_i[0]
    |=> addr_err_trap_o) else $error("odd word not trapped");
  byte_lane_a: assert property (byte_rd_s |->
    x_rdata_o[15:8] == 8'h00
    && wreg_load_o[15:8] == $past(wreg_old_i[15:8], 2))
    else $error("byte read lanes wrong");
  read_lat_a: assert property (
    acc_go && !acc_write_i |=> ##1 rd_valid_o) else $error("no read data");
  mac_lat_a: assert property (
    mac_s |-> ##2 (mac_valid_o && rd_valid_o)) else $error("no dual data");
  push_sp_a: assert property (
    push_i |=> stack_pointer_o == $past(stack_pointer_o) + 16'h0002)
    else $error("push step wrong");
  pop_sp_a: assert property (
    pop_i && !push_i |=> stack_pointer_o == $past(stack_pointer_o) - 16'h0002)
    else $error("pop step wrong");
  stack_floor_a: assert property (
    pop_i && !push_i && stack_pointer_o == 16'h0800 |=> stack_err_trap_o)
    else $error("underflow not trapped");
  trap_cause_a: assert property (
    addr_err_trap_o |-> $past(acc_req_i || mac_req_i))
    else $error("address trap without access");
  ptr_step_a: assert property (rst_b_i |=> ptr_next_o ==
    $past(step_ptr_i) + (($past(step_byte_i) && !$past(step_word_only_i))
    ? 16'h0001 : 16'h0002)) else $error("pointer step wrong");
  near_addr_a: assert property (acc_go && acc_src_i == 2'h1 |=>
    effective_addr_o == {3'h0, $past(acc_addr_i[12:0])})
    else $error("near address wrong");
  full_addr_a: assert property (acc_go && acc_src_i == 2'h2 |=>
    effective_addr_o == $past(acc_addr_i)) else $error("direct address wrong");
endmodule // dsa_core_chk
bind dsa_core dsa_core_chk dsa_core_chk_i (.clk_i, .rst_b_i, .acc_req_i,
  .acc_write_i, .acc_byte_i, .acc_src_i, .acc_addr_i, .wreg_old_i,
  .mac_req_i, .push_i, .pop_i, .step_ptr_i, .step_byte_i, .step_word_only_i,
  .x_rdata_o, .rd_valid_o, .mac_valid_o, .wreg_load_o, .effective_addr_o,
  .stack_pointer_o, .ptr_next_o, .addr_err_trap_o, .stack_err_trap_o);

// ==== testbench/dsa_wreg_model.sv ====
/* Working register of the core execution unit.
   Assumes load strobe and value come from the access block. */
`timescale 1ns/100ps
module dsa_wreg_model (
  input wire clk_i,
  input wire rst_b_i,
  input wire load_i,
  input wire [15:0] value_i,
  output reg [15:0] wreg_o
);
  // Nonzero high byte, so a lost merge shows
  always @(posedge clk_i) begin
    if (!rst_b_i) wreg_o <= 16'h1234;
    else if (load_i) wreg_o <= value_i;
  end
endmodule // dsa_wreg_model

// ==== testbench/test_data_space_access_stack_check.sv ====
/* Self-checking bench of dsa_core with a working register model.
   Assumes the design files under rtl/ and the bound checker. */
`timescale 1ns/100ps
module test_data_space_access_stack_check;
  reg clk_i = 1'b0, rst_b_i = 1'b0;
  reg acc_req_i = '0, acc_write_i = '0, acc_byte_i = '0, mac_req_i = '0;
  reg mac_x_sel_i = '0, mac_y_sel_i = '0, push_i = '0, pop_i = '0;
  reg stack_limit_we_i = '0, step_byte_i = '0, step_word_only_i = '0;
  reg [1:0] acc_src_i = '0, push_kind_i = '0;
  reg [7:0] status_low_byte_i = '0;
  reg [15:0] acc_addr_i = '0, acc_wdata_i = '0, push_data_i = '0;
  reg [15:0] step_ptr_i = '0, stack_limit_wdata_i = '0;
  reg [15:0] x_fetch_pointer_a_i = '0, x_fetch_pointer_b_i = '0;
  reg [15:0] y_fetch_pointer_a_i = '0, y_fetch_pointer_b_i = '0;
  wire [15:0] wreg_old_i, x_rdata_o, y_rdata_o, wreg_load_o;
  wire [15:0] effective_addr_o, stack_pointer_o, ptr_next_o;
  wire rd_valid_o, mac_valid_o, addr_err_trap_o, stack_err_trap_o;
  integer n_errors = 0, tests_run = 0, cyc = 0, n_at = 0, n_st = 0;
  integer a0, s0, i;
  reg ta, ts;
  dsa_core dsa_core_i (.clk_i, .rst_b_i, .acc_req_i, .acc_write_i,
    .acc_byte_i, .acc_src_i, .acc_addr_i, .acc_wdata_i, .wreg_old_i,
    .mac_req_i, .mac_x_sel_i, .mac_y_sel_i, .x_fetch_pointer_a_i,
    .x_fetch_pointer_b_i, .y_fetch_pointer_a_i, .y_fetch_pointer_b_i,
    .push_i, .push_kind_i, .push_data_i, .status_low_byte_i, .pop_i,
    .stack_limit_we_i, .stack_limit_wdata_i, .step_ptr_i, .step_byte_i,
    .step_word_only_i, .x_rdata_o, .y_rdata_o, .rd_valid_o, .mac_valid_o,
    .wreg_load_o, .effective_addr_o, .stack_pointer_o, .ptr_next_o,
    .addr_err_trap_o, .stack_err_trap_o);
  dsa_wreg_model dsa_wreg_model_i (.clk_i, .rst_b_i, .load_i(rd_valid_o),
    .value_i(wreg_load_o), .wreg_o(wreg_old_i));
  always #50 clk_i = ~clk_i;
  task give_verdict;
    begin
      if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // Trap pulses last one cycle, so count them here
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (addr_err_trap_o) n_at <= n_at + 1;
    if (stack_err_trap_o) n_st <= n_st + 1;
    if (cyc == 2000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // k: 0 access, 1 push, 2 pop, 3 dual fetch; w also picks pointer b
  task run(input [1:0] k, input w, b, input [1:0] s, input [15:0] a, d);
    begin
      a0 = n_at;
      s0 = n_st;
      @(posedge clk_i);
      acc_req_i <= k == 2'h0;
      push_i <= k == 2'h1;
      pop_i <= k == 2'h2;
      mac_req_i <= k == 2'h3;
      acc_write_i <= w;
      acc_byte_i <= b;
      acc_src_i <= s;
      push_kind_i <= s;
      acc_addr_i <= a;
      acc_wdata_i <= d;
      push_data_i <= d;
      mac_x_sel_i <= w;
      mac_y_sel_i <= w;
      // Unselected pointer aims at unmapped space
      x_fetch_pointer_a_i <= w ? a ^ 16'h4000 : a;
      x_fetch_pointer_b_i <= w ? a : a ^ 16'h4000;
      y_fetch_pointer_a_i <= w ? d ^ 16'h4000 : d;
      y_fetch_pointer_b_i <= w ? d : d ^ 16'h4000;
      @(posedge clk_i);
      {acc_req_i, push_i, pop_i, mac_req_i} <= 4'h0;
      repeat (2) @(posedge clk_i);
      #1;
      ta = n_at != a0;
      ts = n_st != s0;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    #1 chk(stack_pointer_o, 16'h0800);
    run(0, 1, 0, 0, 16'h0802, 16'hA55A);
    run(0, 1, 1, 0, 16'h0803, 16'h003C);
    run(0, 1, 0, 0, 16'h0804, 16'h1111);
    run(0, 1, 0, 0, 16'h0805, 16'hFFFF);
    chk(ta, 1'b1);
    run(0, 0, 1, 0, 16'h0803, 16'h0000);
    chk(x_rdata_o, 16'h003C);
    chk(wreg_load_o, 16'h123C);
    run(0, 0, 0, 0, 16'h0802, 16'h0000);
    chk(x_rdata_o, 16'h3C5A);
    run(0, 0, 0, 0, 16'h0804, 16'h0000);
    chk(x_rdata_o, 16'h1111);
    run(0, 0, 0, 1, 16'hE804, 16'h0000);
    chk(x_rdata_o, 16'h1111);
    run(0, 1, 0, 2, 16'h1800, 16'h7777);
    run(0, 0, 0, 0, 16'h4000, 16'h0000);
    chk(x_rdata_o, 16'h0000);
    run(3, 0, 0, 0, 16'h0802, 16'h1800);
    chk(x_rdata_o, 16'h3C5A);
    chk(y_rdata_o, 16'h7777);
    run(3, 1, 0, 0, 16'h1800, 16'h0802);
    chk(x_rdata_o, 16'h0000);
    chk(y_rdata_o, 16'h0000);
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clk_i);
      step_ptr_i <= 16'h0100;
      step_byte_i <= i != 1;
      step_word_only_i <= i == 2;
      repeat (2) @(posedge clk_i);
      #1 chk(ptr_next_o, i == 0 ? 16'h0101 : 16'h0102);
    end
    @(posedge clk_i);
    stack_limit_we_i <= 1'b1;
    stack_limit_wdata_i <= 16'h0803;
    status_low_byte_i <= 8'h5A;
    @(posedge clk_i);
    stack_limit_we_i <= 1'b0;
    @(posedge clk_i); // Gap before stack use
    run(1, 0, 0, 0, 16'h0000, 16'hABCD);
    run(1, 0, 0, 1, 16'h0000, 16'h1234);
    chk(ts, 1'b0);
    run(1, 0, 0, 2, 16'h0000, 16'hFF77);
    chk(ts, 1'b1);
    chk(stack_pointer_o, 16'h0806);
    run(2, 0, 0, 0, 16'h0000, 16'h0000);
    chk(x_rdata_o, 16'h5A77);
    run(0, 0, 0, 3, 16'h0000, 16'h0000);
    chk(x_rdata_o, 16'h5A77);
    chk(stack_pointer_o, 16'h0804);
    chk(ts, 1'b1);
    run(2, 0, 0, 0, 16'h0000, 16'h0000);
    chk(x_rdata_o, 16'h0034);
    run(2, 0, 0, 0, 16'h0000, 16'h0000);
    chk(x_rdata_o, 16'hABCD);
    chk(ts, 1'b0);
    run(2, 0, 0, 0, 16'h0000, 16'h0000);
    chk(ts, 1'b1);
    give_verdict;
  end
endmodule // test_data_space_access_stack_check
